// ===== hdl/odp_regs.vh
// Constants for the octal DDR pseudo-static RAM device model: commands,
// mode register map, reset values, field positions and timing counts.
// Assumes the includer runs on a 100 MHz internal clock.
// Summary of operation
// - Self-initialisation takes 150 us after supplies
// - Power-down entries wait their power-up times
// - Reset pin pulse completes phase two
// - Reset pin restores every configuration register
// - Reset pin active low, idles high
// - Reset command restores configuration registers
// - Mask high on write blocks that byte
// - Device drives strobe with read data
// - Select high means standby, bus ignored
// - Register accesses accept odd addresses
// - Default burst is hybrid wrap 32
// - Wrap 16/32/64/1K, standard or hybrid
// - Linear commands never wrap
// - Bursts unlimited within select-low time
// - Two bytes per clock, both edges
// - 8M bytes, 10-bit column, 13-bit row
// - Command first rise, address next four edges
`ifndef ODP_REGS_VH
`define ODP_REGS_VH

// ****************************************************************
// Commands
// ****************************************************************
`define ODP_CMD_RD      8'h00
`define ODP_CMD_WR      8'h80
`define ODP_CMD_RD_LIN  8'h20
`define ODP_CMD_WR_LIN  8'hA0
`define ODP_CMD_MRR     8'h40
`define ODP_CMD_MRW     8'hC0
`define ODP_CMD_GRST    8'hFF

// ****************************************************************
// Mode registers
// ****************************************************************
`define ODP_MA_MR0      8'h00
`define ODP_MA_MR1      8'h01
`define ODP_MA_MR2      8'h02
`define ODP_MA_MR3      8'h03
`define ODP_MA_MR4      8'h04
`define ODP_MA_MR8      8'h08
`define ODP_MR0_RST     8'h09
`define ODP_MR4_RST     8'h00
`define ODP_MR8_RST     8'h05
`define ODP_MR0_LC_MSB  4
`define ODP_MR0_LC_LSB  2
`define ODP_MR8_BT_BIT  2
`define ODP_MR8_BL_MSB  1
`define ODP_MR8_BL_LSB  0
`define ODP_LC_OFFSET   4'h3

// ****************************************************************
// Array and pins
// ****************************************************************
`define ODP_ADDR_W      23
`define ODP_MEM_DEPTH   8388608
`define ODP_PIN_W       12
`define ODP_PIN_MASK    8
`define ODP_PIN_CLK     9
`define ODP_PIN_CS      10
`define ODP_PIN_RST     11
`define ODP_PIN_RSTVAL  12'hC00

// ****************************************************************
// Timing
// ****************************************************************
`define ODP_CLK_MHZ     100
`define ODP_T_INIT_US   150
`define ODP_INIT_CYC    (`ODP_T_INIT_US * `ODP_CLK_MHZ)
`define ODP_T_RST_NS    2000
`define ODP_RST_CYC     ((`ODP_T_RST_NS * `ODP_CLK_MHZ + 999) / 1000)
`define ODP_T_HSPU_US   150
`define ODP_HSPU_CYC    (`ODP_T_HSPU_US * `ODP_CLK_MHZ)
`define ODP_T_DPDP_US   150
`define ODP_DPDP_CYC    (`ODP_T_DPDP_US * `ODP_CLK_MHZ)

`endif

// ===== hdl/odp_mem.v
// Byte array of the device, one write port and one registered read port.
// Assumes its owner holds rd_addr steady one cycle before using rd_data.
`timescale 1ns/100ps
`default_nettype none
`include "odp_regs.vh"
module odp_mem (
	// Clock
	input  wire                   ref_clk,
	// Write port
	input  wire                   wr_en,
	input  wire [`ODP_ADDR_W-1:0] wr_addr,
	input  wire [7:0]             wr_data,
	// Read port
	input  wire [`ODP_ADDR_W-1:0] rd_addr,
	output reg  [7:0]             rd_data
);
	// Contents are not reset: a reset never promises the array survives
	reg [7:0] mem [0:`ODP_MEM_DEPTH-1];

	always @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ===== hdl/odp_device.v
// Device side of an octal DDR pseudo-static RAM: power-up sequence,
// reset pin and reset command, command/address capture, burst engine.
// Assumes the host clock is slower than ref_clk / 8 so every pin edge is
// seen after three-stage sampling.
`timescale 1ns/100ps
`default_nettype none
`include "odp_regs.vh"
module odp_device #(
	parameter [15:0] INIT_CYCLES = `ODP_INIT_CYC,
	parameter [15:0] HSPU_CYCLES = `ODP_HSPU_CYC,
	parameter [15:0] DPDP_CYCLES = `ODP_DPDP_CYC,
	// Identity value is arbitrary
	parameter [4:0]  VENDOR_ID   = 5'h12
) (
	// Clock and power-on reset
	input  wire       ref_clk,
	input  wire       rst_b,
	// Host control pins
	input  wire       pin_cs_b,
	input  wire       pin_clk,
	input  wire       pin_reset_b,
	// Shared address/data bus
	input  wire [7:0] pin_dq_in,
	output reg  [7:0] pin_dq_out,
	output reg        pin_dq_oe,
	// Strobe and write mask
	input  wire       strobe_mask_line_in,
	output reg        strobe_mask_line_out,
	output reg        strobe_mask_line_oe,
	// Status
	output wire       init_done,
	output wire       dev_ready,
	output wire       half_sleep_ok,
	output wire       deep_pd_ok
);
	localparam [1:0] INIT_P1 = 2'h0;
	localparam [1:0] INIT_P2 = 2'h1;
	localparam [1:0] RECOV   = 2'h2;
	localparam [1:0] READY   = 2'h3;

	localparam [2:0] B_CMD  = 3'h0;
	localparam [2:0] B_ADDR = 3'h1;
	localparam [2:0] B_LAT  = 3'h2;
	localparam [2:0] B_DATA = 3'h3;
	localparam [2:0] B_HOLD = 3'h4;

	localparam [`ODP_PIN_W-1:0] PIN_RSTVAL = `ODP_PIN_RSTVAL;
	localparam [15:0]           RST_CYC    = `ODP_RST_CYC;

	wire [`ODP_PIN_W-1:0]  pin_raw;
	wire [`ODP_PIN_W-1:0]  pin_f;
	wire [7:0]             dq_f;
	wire                   mask_f;
	wire                   clk_f;
	wire                   cs_f;
	wire                   rstpin_f;
	reg                    clk_d;
	wire                   rise;
	wire                   fall;
	wire                   edge_any;
	reg  [1:0]             init_st;
	reg  [15:0]            cnt;
	reg  [2:0]             bus_st;
	reg  [7:0]             cmd;
	reg  [23:0]            a_sh;
	reg  [1:0]             a_cnt;
	reg  [`ODP_ADDR_W-1:0] addr;
	reg  [7:0]             ma;
	reg  [3:0]             lat_cnt;
	reg  [10:0]            bcnt;
	reg  [7:0]             mr0;
	reg  [7:0]             mr4;
	reg  [7:0]             mr8;
	reg  [10:0]            wmask;
	reg  [7:0]             mr_rd;
	reg  [`ODP_ADDR_W-1:0] next_addr;
	wire [`ODP_ADDR_W-1:0] inc;
	wire [`ODP_ADDR_W-1:0] wm_ext;
	wire [23:0]            a_next;
	wire [7:0]             mem_rdata;
	wire                   is_rd;
	wire                   is_wr;
	wire                   is_mrr;
	wire                   is_mrw;
	wire                   is_lin;
	wire                   hybrid;
	wire                   bus_en;
	wire                   grst_hit;
	wire                   cfg_clear;
	wire                   data_edge;
	wire                   mem_we;
	wire [3:0]             lc;

	// ****************************************************************
	// Pin sampling
	// ****************************************************************
	assign pin_raw = {pin_reset_b, pin_cs_b, pin_clk, strobe_mask_line_in,
		pin_dq_in};

	genvar gi;
	generate
		for (gi = 0; gi < `ODP_PIN_W; gi = gi + 1) begin : g_sync
			reg s1;
			reg s2;
			reg s3;
			reg flt;
			// Reset pin and select idle high, as with the pull-up fitted
			always @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					s1  <= PIN_RSTVAL[gi];
					s2  <= PIN_RSTVAL[gi];
					s3  <= PIN_RSTVAL[gi];
					flt <= PIN_RSTVAL[gi];
				end else begin
					s1 <= pin_raw[gi];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						flt <= s3;
					end
				end
			end
			assign pin_f[gi] = flt;
		end
	endgenerate

	assign dq_f     = pin_f[7:0];
	assign mask_f   = pin_f[`ODP_PIN_MASK];
	assign clk_f    = pin_f[`ODP_PIN_CLK];
	assign cs_f     = pin_f[`ODP_PIN_CS];
	assign rstpin_f = pin_f[`ODP_PIN_RST];

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_d <= 1'b0;
		end else begin
			clk_d <= clk_f;
		end
	end

	assign rise     = clk_f & ~clk_d;
	assign fall     = ~clk_f & clk_d;
	assign edge_any = rise | fall;

	// ****************************************************************
	// Power-up and reset sequence
	// ****************************************************************
	assign grst_hit = bus_en && !cs_f && bus_st == B_CMD && rise &&
		dq_f == `ODP_CMD_GRST;
	assign cfg_clear = grst_hit || (init_st != INIT_P1 && !rstpin_f);

	// Pins are not looked at during phase one; the host keeps them idle
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			init_st <= INIT_P1;
			cnt     <= 16'h0000;
		end else begin
			case (init_st)
			INIT_P1: begin
				if (cnt == INIT_CYCLES - 16'h0001) begin
					init_st <= INIT_P2;
					cnt     <= 16'h0000;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
			INIT_P2, READY: begin
				if (cfg_clear) begin
					init_st <= RECOV;
					cnt     <= 16'h0000;
				end else if (init_st == READY && cnt != 16'hFFFF) begin
					cnt <= cnt + 16'h0001;
				end
			end
			RECOV: begin
				// Counting starts only once the reset pin is back high
				if (!rstpin_f) begin
					cnt <= 16'h0000;
				end else if (cnt == RST_CYC - 16'h0001) begin
					init_st <= READY;
					cnt     <= 16'h0000;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
			default: begin
				init_st <= INIT_P1;
				cnt     <= 16'h0000;
			end
			endcase
		end
	end

	assign init_done     = init_st != INIT_P1;
	assign dev_ready     = init_st == READY;
	assign half_sleep_ok = dev_ready && cnt >= HSPU_CYCLES;
	assign deep_pd_ok    = dev_ready && cnt >= DPDP_CYCLES;

	// ****************************************************************
	// Mode registers
	// ****************************************************************
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mr0 <= `ODP_MR0_RST;
			mr4 <= `ODP_MR4_RST;
			mr8 <= `ODP_MR8_RST;
		end else if (cfg_clear) begin
			mr0 <= `ODP_MR0_RST;
			mr4 <= `ODP_MR4_RST;
			mr8 <= `ODP_MR8_RST;
		end else if (data_edge && is_mrw && bcnt == 11'h000) begin
			// Full 8-bit decode, so odd addresses are legal and unmapped
			case (ma)
			`ODP_MA_MR0: mr0 <= dq_f;
			`ODP_MA_MR4: mr4 <= dq_f;
			`ODP_MA_MR8: mr8 <= dq_f;
			default:     mr0 <= mr0;
			endcase
		end
	end

	always @* begin
		case (ma)
		`ODP_MA_MR0: mr_rd = mr0;
		`ODP_MA_MR1: mr_rd = {3'h0, VENDOR_ID};
		`ODP_MA_MR4: mr_rd = mr4;
		`ODP_MA_MR8: mr_rd = mr8;
		default:     mr_rd = 8'h00;
		endcase
	end

	assign lc = {1'b0, mr0[`ODP_MR0_LC_MSB:`ODP_MR0_LC_LSB]} + `ODP_LC_OFFSET;

	// ****************************************************************
	// Burst address engine
	// ****************************************************************
	always @* begin
		case (mr8[`ODP_MR8_BL_MSB:`ODP_MR8_BL_LSB])
		2'h0:    wmask = 11'h00F;
		2'h1:    wmask = 11'h01F;
		2'h2:    wmask = 11'h03F;
		default: wmask = 11'h3FF;
		endcase
	end

	assign hybrid = mr8[`ODP_MR8_BT_BIT];
	assign inc    = addr + {{(`ODP_ADDR_W-1){1'b0}}, 1'b1};
	assign wm_ext = {{(`ODP_ADDR_W-11){1'b0}}, wmask};

	always @* begin
		if (is_lin || (hybrid && bcnt > wmask)) begin
			next_addr = inc;
		end else if (hybrid && bcnt == wmask) begin
			// First pass done: continue at the following wrap block
			next_addr = (addr | wm_ext) + {{(`ODP_ADDR_W-1){1'b0}}, 1'b1};
		end else begin
			next_addr = (addr & ~wm_ext) | (inc & wm_ext);
		end
	end

	// ****************************************************************
	// Command, address and data phases
	// ****************************************************************
	assign is_rd  = cmd == `ODP_CMD_RD || cmd == `ODP_CMD_RD_LIN;
	assign is_wr  = cmd == `ODP_CMD_WR || cmd == `ODP_CMD_WR_LIN;
	assign is_mrr = cmd == `ODP_CMD_MRR;
	assign is_mrw = cmd == `ODP_CMD_MRW;
	assign is_lin = cmd == `ODP_CMD_RD_LIN || cmd == `ODP_CMD_WR_LIN;
	assign bus_en = (init_st == INIT_P2 || init_st == READY) && rstpin_f;
	assign a_next = {a_sh[15:0], dq_f};

	assign data_edge = !cs_f && edge_any && (bus_st == B_DATA ||
		(bus_st == B_LAT && rise && lat_cnt == 4'h1));
	assign mem_we = data_edge && is_wr && !mask_f;

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_st               <= B_CMD;
			cmd                  <= 8'h00;
			a_sh                 <= 24'h000000;
			a_cnt                <= 2'h0;
			addr                 <= {`ODP_ADDR_W{1'b0}};
			ma                   <= 8'h00;
			lat_cnt              <= 4'h0;
			bcnt                 <= 11'h000;
			pin_dq_out           <= 8'h00;
			pin_dq_oe            <= 1'b0;
			strobe_mask_line_out <= 1'b0;
			strobe_mask_line_oe  <= 1'b0;
		end else if (cs_f) begin
			bus_st              <= B_CMD;
			pin_dq_oe           <= 1'b0;
			strobe_mask_line_oe <= 1'b0;
		end else if (!bus_en) begin
			bus_st              <= B_HOLD;
			pin_dq_oe           <= 1'b0;
			strobe_mask_line_oe <= 1'b0;
		end else begin
			case (bus_st)
			B_CMD: begin
				if (rise) begin
					cmd   <= dq_f;
					a_cnt <= 2'h0;
					bcnt  <= 11'h000;
					// Only the reset command is taken before ready
					if (init_st == READY && dq_f != `ODP_CMD_GRST) begin
						bus_st <= B_ADDR;
					end else begin
						bus_st <= B_HOLD;
					end
				end
			end
			B_ADDR: begin
				if (edge_any) begin
					a_sh  <= a_next;
					a_cnt <= a_cnt + 2'h1;
					if (a_cnt == 2'h3) begin
						addr    <= a_next[`ODP_ADDR_W-1:0];
						ma      <= dq_f;
						lat_cnt <= is_mrw ? 4'h1 : lc;
						if (is_rd || is_wr || is_mrr || is_mrw) begin
							bus_st <= B_LAT;
						end else begin
							bus_st <= B_HOLD;
						end
						if (is_rd || is_mrr) begin
							strobe_mask_line_out <= 1'b0;
							strobe_mask_line_oe  <= 1'b1;
						end
					end
				end
			end
			B_LAT, B_DATA: begin
				if (bus_st == B_LAT && rise && lat_cnt != 4'h1) begin
					lat_cnt <= lat_cnt - 4'h1;
				end
				if (data_edge) begin
					bus_st <= B_DATA;
					addr   <= next_addr;
					if (bcnt != 11'h7FF) begin
						bcnt <= bcnt + 11'h001;
					end
					if (is_rd || is_mrr) begin
						pin_dq_out           <= is_mrr ? mr_rd : mem_rdata;
						pin_dq_oe            <= 1'b1;
						strobe_mask_line_out <= rise;
					end
				end
			end
			B_HOLD: begin
				bus_st <= B_HOLD;
			end
			default: begin
				bus_st <= B_HOLD;
			end
			endcase
		end
	end

	odp_mem u_mem (
		.ref_clk (ref_clk),
		.wr_en   (mem_we),
		.wr_addr (addr),
		.wr_data (dq_f),
		.rd_addr (addr),
		.rd_data (mem_rdata)
	);
endmodule
`default_nettype wire

// ===== tb/odp_assertions.sv
// Checker bound to the octal DDR device: power-up, standby, read strobe.
// Assumes the host clock runs at least eight times slower than ref_clk.
`timescale 1ns/100ps
`default_nettype none
module odp_assertions #(
	parameter [15:0] INIT_CYCLES = 16'd50
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst_b,
	// Host pins
	input wire pin_cs_b,
	input wire pin_clk,
	input wire pin_reset_b,
	// Device drive and status
	input wire pin_dq_oe,
	input wire strobe_mask_line_out,
	input wire strobe_mask_line_oe,
	input wire init_done,
	input wire dev_ready,
	input wire half_sleep_ok,
	input wire deep_pd_ok
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	logic [15:0] up_cnt;
	// Saturates so a long run never wraps back into phase one
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			up_cnt <= 16'h0000;
		else if (up_cnt != 16'hFFFF)
			up_cnt <= up_cnt + 16'h0001;
	end
	sequence host_edge_s;
		pin_dq_oe && !pin_cs_b && $changed(pin_clk);
	endsequence
	sequence strobe_follows_s;
		##[2:7] strobe_mask_line_out == pin_clk;
	endsequence
	init_early_a: assert property (up_cnt < INIT_CYCLES - 16'd1
		|-> !init_done) else $error("init done too early");
	init_late_a: assert property (up_cnt > INIT_CYCLES + 16'd2
		|-> init_done) else $error("init done missing");
	standby_a: assert property (pin_cs_b[*8]
		|-> !pin_dq_oe && !strobe_mask_line_oe) else $error("drive in standby");
	pin_reset_a: assert property (!pin_reset_b[*8]
		|-> !dev_ready && !pin_dq_oe) else $error("active under reset pin");
	recovery_a: assert property ($rose(pin_reset_b)
		|-> (!dev_ready)[*8]) else $error("ready without recovery");
	pw_wait_a: assert property ($rose(dev_ready)
		|-> (!half_sleep_ok && !deep_pd_ok)[*8]) else $error("power-up wait");
	pre_strobe_a: assert property ($rose(strobe_mask_line_oe)
		|-> !strobe_mask_line_out) else $error("strobe not low in latency");
	first_byte_a: assert property ($rose(pin_dq_oe)
		|-> strobe_mask_line_out && strobe_mask_line_oe)
		else $error("first byte without strobe high");
	ddr_strobe_a: assert property (host_edge_s |-> strobe_follows_s)
		else $error("strobe not following host edge");
endmodule
bind odp_device odp_assertions #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
	.ref_clk              (ref_clk),
	.rst_b                (rst_b),
	.pin_cs_b             (pin_cs_b),
	.pin_clk              (pin_clk),
	.pin_reset_b          (pin_reset_b),
	.pin_dq_oe            (pin_dq_oe),
	.strobe_mask_line_out (strobe_mask_line_out),
	.strobe_mask_line_oe  (strobe_mask_line_oe),
	.init_done            (init_done),
	.dev_ready            (dev_ready),
	.half_sleep_ok        (half_sleep_ok),
	.deep_pd_ok           (deep_pd_ok)
);
`default_nettype wire

// ===== tb/odp_host.sv
// Host controller model driving the octal DDR pins of the device.
// Assumes ref_clk runs at least eight times the host clock rate.
`timescale 1ns/100ps
`default_nettype none
`include "odp_regs.vh"
module odp_host (
	// Clock
	input  wire        ref_clk,
	// Host pins
	output logic       cs_b,
	output logic       hclk,
	output logic       rst_pin_b,
	output logic [7:0] dq,
	output logic       mask,
	// Device read data
	input  wire  [7:0] dq_out
);
	logic [7:0] wd [0:7];
	logic [7:0] rd [0:7];
	logic [7:0] wm;
	initial begin
		cs_b = 1'b1;
		hclk = 1'b0;
		rst_pin_b = 1'b1;
		dq = 8'h00;
		mask = 1'b0;
		wm = 8'h00;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Held four cycles each side so the pin sampling sees stable data
	task automatic dedge(input [7:0] d, input m);
		dq = d;
		mask = m;
		wt(4);
		hclk = ~hclk;
		wt(4);
	endtask
	// Bus released: inverting dq keeps stale data from looking valid
	task automatic redge(output [7:0] q);
		dq = ~dq;
		mask = 1'b0;
		wt(1);
		hclk = ~hclk;
		wt(7);
		q = dq_out;
	endtask
	task automatic frame(input [7:0] c, input [22:0] a, input int n);
		int         i;
		logic [7:0] q;
		cs_b = 1'b0;
		wt(4);
		dedge(c, 1'b0);
		dedge(8'h00, 1'b0);
		dedge({1'b0, a[22:16]}, 1'b0);
		dedge(a[15:8], 1'b0);
		dedge(a[7:0], 1'b0);
		repeat (c == `ODP_CMD_MRW ? 1 : 9) redge(q);
		for (i = 0; i < n; i++) begin
			if (c[7])
				dedge(wd[i], wm[i]);
			else
				redge(rd[i]);
		end
		cs_b = 1'b1;
		wt(12);
	endtask
	task automatic greset();
		cs_b = 1'b0;
		wt(4);
		repeat (8) dedge(`ODP_CMD_GRST, 1'b0);
		cs_b = 1'b1;
		wt(4);
	endtask
	task automatic pin_reset();
		rst_pin_b = 1'b0;
		wt(10);
		rst_pin_b = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the octal DDR device driven by a host model.
// Assumes the host model changes pins only on falling ref_clk edges.
`timescale 1ns/100ps
`default_nettype none
`include "odp_regs.vh"
module testbench;
	// Identity value is arbitrary
	localparam [4:0] VID = 5'h0A;
	logic       ref_clk;
	logic       rst_b;
	wire        cs_b, hclk, rst_pin_b, mask, dq_oe, sml_out, sml_oe;
	wire  [7:0] hdq, dq_out;
	wire        init_done, dev_ready, hs_ok, pd_ok;
	int         fails, check_count, cyc;
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;
	odp_host host (.ref_clk(ref_clk), .cs_b(cs_b), .hclk(hclk),
		.rst_pin_b(rst_pin_b), .dq(hdq), .mask(mask), .dq_out(dq_out));
	odp_device #(.INIT_CYCLES(16'd50), .HSPU_CYCLES(16'd60),
		.DPDP_CYCLES(16'd60), .VENDOR_ID(VID)) DUT (
		.ref_clk(ref_clk), .rst_b(rst_b), .pin_cs_b(cs_b),
		.pin_clk(hclk), .pin_reset_b(rst_pin_b),
		// Shared lines show whichever side drives them
		.pin_dq_in(dq_oe ? dq_out : hdq), .pin_dq_out(dq_out),
		.pin_dq_oe(dq_oe), .strobe_mask_line_in(sml_oe ? sml_out : mask),
		.strobe_mask_line_out(sml_out), .strobe_mask_line_oe(sml_oe),
		.init_done(init_done), .dev_ready(dev_ready),
		.half_sleep_ok(hs_ok), .deep_pd_ok(pd_ok));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk8(input [7:0] got, input [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic wait_ready();
		int i;
		for (i = 0; i < 400 && dev_ready !== 1'b1; i++)
			host.wt(1);
		chk1(dev_ready, 1'b1);
	endtask
	task automatic mrr(input [7:0] ma, input [7:0] exp);
		host.frame(`ODP_CMD_MRR, {15'h0000, ma}, 2);
		chk8(host.rd[0], exp);
	endtask
	task automatic mrw(input [7:0] ma, input [7:0] v);
		host.wd[0] = v;
		host.wd[1] = v;
		host.frame(`ODP_CMD_MRW, {15'h0000, ma}, 2);
	endtask
	task automatic wr4(input [7:0] c, input [22:0] a, input [7:0] b);
		int i;
		for (i = 0; i < 4; i++)
			host.wd[i] = b + i[7:0];
		host.frame(c, a, 4);
	endtask
	task automatic rd2(input [22:0] a, input [7:0] b);
		host.frame(`ODP_CMD_RD_LIN, a, 2);
		chk8(host.rd[0], b);
		chk8(host.rd[1], b + 8'h01);
	endtask
	task automatic t_power();
		host.wt(40);
		chk1(init_done, 1'b0);
		chk1(dev_ready, 1'b0);
		host.wt(20);
		chk1(init_done, 1'b1);
		host.pin_reset();
		wait_ready();
		chk1(hs_ok, 1'b0);
		chk1(pd_ok, 1'b0);
		host.wt(70);
		chk1(hs_ok, 1'b1);
		chk1(pd_ok, 1'b1);
		mrr(`ODP_MA_MR1, {3'b000, VID});
		mrr(`ODP_MA_MR8, `ODP_MR8_RST);
		$display("test power-up done");
	endtask
	task automatic t_mask();
		wr4(`ODP_CMD_WR_LIN, 23'h7FFFF0, 8'hA0);
		host.wd[0] = 8'h11;
		host.wd[1] = 8'h22;
		host.wm = 8'h02;
		host.frame(`ODP_CMD_WR_LIN, 23'h7FFFF0, 2);
		host.wm = 8'h00;
		host.frame(`ODP_CMD_RD_LIN, 23'h7FFFF0, 4);
		chk8(host.rd[0], 8'h11);
		chk8(host.rd[1], 8'hA1);
		chk8(host.rd[3], 8'hA3);
		$display("test mask done");
	endtask
	task automatic t_wrap();
		int          k;
		logic [22:0] len;
		wr4(`ODP_CMD_WR, 23'h00001E, 8'h30);
		rd2(23'h000000, 8'h32);
		// Wrapping read: third byte comes back from the block start
		host.frame(`ODP_CMD_RD, 23'h00001E, 4);
		chk8(host.rd[2], 8'h32);
		// Wrap of every code: the last two bytes land at the block start
		for (k = 0; k < 8; k++) begin
			mrw(`ODP_MA_MR8, {5'h00, k[2:0]});
			len = (k[1:0] == 2'b11) ? 23'd1024 : 23'd16 << k[1:0];
			wr4(`ODP_CMD_WR, len - 23'd2, {1'b0, k[2:0], 4'h0});
			rd2(23'h000000, {1'b0, k[2:0], 4'h2});
		end
		mrw(`ODP_MA_MR8, 8'h00);
		wr4(`ODP_CMD_WR_LIN, 23'h00000E, 8'h80);
		rd2(23'h000010, 8'h82);
		$display("test wrap done");
	endtask
	task automatic t_standby();
		repeat (8) host.dedge(`ODP_CMD_RD, 1'b0);
		chk1(dq_oe, 1'b0);
		chk1(sml_oe, 1'b0);
		host.pin_reset();
		chk1(dev_ready, 1'b0);
		wait_ready();
		mrr(`ODP_MA_MR8, `ODP_MR8_RST);
		$display("test standby and pin reset done");
	endtask
	task automatic t_cmd_reset();
		rst_b = 1'b0;
		host.wt(3);
		rst_b = 1'b1;
		host.wt(60);
		chk1(dev_ready, 1'b0);
		host.greset();
		wait_ready();
		mrr(`ODP_MA_MR0, `ODP_MR0_RST);
		$display("test reset command done");
	endtask
	initial begin
		rst_b = 1'b0;
		fails = 0;
		check_count = 0;
		host.wt(10);
		rst_b = 1'b1;
		t_power();
		t_mask();
		t_wrap();
		t_standby();
		t_cmd_reset();
		end_of_test();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 25000) begin
			fails++;
			end_of_test();
		end
	end
endmodule
`default_nettype wire
